// file: rtl/mad_pkg.sv
// Shared constants and types of the addressing byte decoder
package mad_pkg;

    // ------------------------------------------------------------
    // Addressing byte field positions
    // ------------------------------------------------------------
    localparam int MOD_MSB = 7;
    localparam int MOD_LSB = 6;
    localparam int REG_MSB = 5;
    localparam int REG_LSB = 3;
    localparam int RM_MSB = 2;
    localparam int RM_LSB = 0;

    // ------------------------------------------------------------
    // Mode field codes
    // ------------------------------------------------------------
    localparam logic [1:0] MOD_NO_DISP = 2'h0;
    localparam logic [1:0] MOD_DISP_BYTE = 2'h1;
    localparam logic [1:0] MOD_DISP_WIDE = 2'h2;
    localparam logic [1:0] MOD_REGISTER = 2'h3;

    // ------------------------------------------------------------
    // Special register/memory codes
    // ------------------------------------------------------------
    localparam logic [2:0] RM_DIRECT_16 = 3'h6;
    localparam logic [2:0] RM_SIB = 3'h4;
    localparam logic [2:0] RM_DIRECT_32 = 3'h5;

    // ------------------------------------------------------------
    // General register numbers, same order for 16 and 32 bits
    // ------------------------------------------------------------
    localparam logic [2:0] GR_ACC = 3'h0;
    localparam logic [2:0] GR_COUNT = 3'h1;
    localparam logic [2:0] GR_DATA = 3'h2;
    localparam logic [2:0] GR_BASE = 3'h3;
    localparam logic [2:0] GR_STACK = 3'h4;
    localparam logic [2:0] GR_FRAME = 3'h5;
    localparam logic [2:0] GR_SRC_IDX = 3'h6;
    localparam logic [2:0] GR_DEST_IDX = 3'h7;

    // Displacement that follows the addressing byte
    typedef enum logic [1:0] {
        DISP_NONE,
        DISP_BYTE,
        DISP_HALFWORD,
        DISP_WORD
    } mad_disp_e;

    // Size of a register operand
    typedef enum logic [1:0] {
        OPSZ_BYTE,
        OPSZ_HALFWORD,
        OPSZ_WORD
    } mad_opsz_e;

endpackage : mad_pkg

// file: rtl/mad_sext.sv
// Displacement extender to the current address width
`timescale 1ns/100ps

module mad_sext #(
    parameter int WIDTH = 32
) (
    input wire logic [WIDTH-1:0] disp_raw,
    input wire mad_pkg::mad_disp_e disp_size,
    input wire logic addr_32,
    output logic [WIDTH-1:0] disp_ext
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WIDTH != 32) begin : g_width_check
        $error("mad_sext: WIDTH must be 32");
    end

    // ------------------------------------------------------------
    // Extension
    // ------------------------------------------------------------
    // Byte displacement fills 16 or 32 bits with its sign bit
    always_comb begin
        disp_ext = '0;
        unique case (disp_size)
            mad_pkg::DISP_NONE: begin
                disp_ext = '0;
            end
            mad_pkg::DISP_BYTE: begin
                if (addr_32) begin
                    disp_ext = {{(WIDTH-8){disp_raw[7]}}, disp_raw[7:0]}; // [RULE_12]
                end else begin
                    disp_ext = {{(WIDTH-16){1'b0}}, {8{disp_raw[7]}}, disp_raw[7:0]}; // [RULE_12]
                end
            end
            mad_pkg::DISP_HALFWORD: begin
                disp_ext = {{(WIDTH-16){1'b0}}, disp_raw[15:0]};
            end
            mad_pkg::DISP_WORD: begin
                disp_ext = disp_raw;
            end
        endcase
    end

endmodule : mad_sext

// file: rtl/mad_decoder.sv
// Addressing byte decoder: address recipe or register operand
//
// Functional notes
// RULE_01 - 16-bit mode 00 forms, displacement only code 110
// RULE_02 - 16-bit 00/110 is direct halfword, data segment
// RULE_03 - 16-bit mode 01 byte, 10 halfword displacement
// RULE_04 - 16-bit frame pointer forms use stack segment
// RULE_05 - Mode 11, width 0 selects byte registers
// RULE_06 - Mode 11, width 1, 16-bit data: halfword registers
// RULE_07 - Mode 11, width 1, 32-bit data: word registers
// RULE_08 - 32-bit code 100 in memory modes announces index byte
// RULE_09 - 32-bit 00/101 direct word, else base plus displacement
// RULE_10 - 32-bit frame pointer base uses stack segment
// RULE_11 - Address width picks the 16 or 32-bit table
// RULE_12 - Byte displacement sign-extended to address width
`timescale 1ns/100ps

module mad_decoder #(
    parameter int DISP_W = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic [7:0] modrm,
    input wire logic addr_32,
    input wire logic data_32,
    input wire logic width_bit,
    input wire logic [DISP_W-1:0] disp_raw,
    output logic out_valid,
    output logic out_is_reg,
    output logic [2:0] out_reg_num,
    output logic out_reg_high,
    output mad_pkg::mad_opsz_e out_reg_size,
    output logic [2:0] out_reg_field,
    output logic out_base_valid,
    output logic [2:0] out_base,
    output logic out_index_valid,
    output logic [2:0] out_index,
    output mad_pkg::mad_disp_e out_disp_size,
    output logic [DISP_W-1:0] out_disp,
    output logic out_seg_stack,
    output logic out_sib_follows
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DISP_W != 32) begin : g_width_check
        $error("mad_decoder: DISP_W must be 32");
    end

    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    logic [1:0] mod_f;
    logic [2:0] rm_f;
    assign mod_f = modrm[mad_pkg::MOD_MSB:mad_pkg::MOD_LSB];
    assign rm_f = modrm[mad_pkg::RM_MSB:mad_pkg::RM_LSB];

    // ------------------------------------------------------------
    // Next-state signals
    // ------------------------------------------------------------
    logic next_valid;
    logic next_is_reg;
    logic [2:0] next_reg_num;
    logic next_reg_high;
    mad_pkg::mad_opsz_e next_reg_size;
    logic [2:0] next_reg_field;
    logic next_base_valid;
    logic [2:0] next_base;
    logic next_index_valid;
    logic [2:0] next_index;
    mad_pkg::mad_disp_e next_disp_size;
    logic [DISP_W-1:0] next_disp;
    logic next_seg_stack;
    logic next_sib_follows;
    logic [DISP_W-1:0] disp_ext;

    // Displacement widened to the address width of this instruction
    mad_sext #(
        .WIDTH(DISP_W)
    ) u_sext (
        .disp_raw(disp_raw),
        .disp_size(next_disp_size),
        .addr_32(addr_32),
        .disp_ext(disp_ext)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Fields hold their last value between accepted bytes
    always_comb begin
        next_valid = in_valid;
        next_is_reg = out_is_reg;
        next_reg_num = out_reg_num;
        next_reg_high = out_reg_high;
        next_reg_size = out_reg_size;
        next_reg_field = out_reg_field;
        next_base_valid = out_base_valid;
        next_base = out_base;
        next_index_valid = out_index_valid;
        next_index = out_index;
        next_disp_size = out_disp_size;
        next_seg_stack = out_seg_stack;
        next_sib_follows = out_sib_follows;
        if (in_valid) begin
            next_is_reg = 1'b0;
            next_reg_num = 3'h0;
            next_reg_high = 1'b0;
            next_reg_size = mad_pkg::OPSZ_BYTE;
            next_reg_field = modrm[mad_pkg::REG_MSB:mad_pkg::REG_LSB];
            next_base_valid = 1'b0;
            next_base = 3'h0;
            next_index_valid = 1'b0;
            next_index = 3'h0;
            next_disp_size = mad_pkg::DISP_NONE;
            next_seg_stack = 1'b0;
            next_sib_follows = 1'b0;
            if (mod_f == mad_pkg::MOD_REGISTER) begin
                // Register operand, same in both address widths
                next_is_reg = 1'b1;
                if (!width_bit) begin
                    next_reg_num = {1'b0, rm_f[1:0]}; // [RULE_05]
                    next_reg_high = rm_f[2]; // [RULE_05]
                    next_reg_size = mad_pkg::OPSZ_BYTE; // [RULE_05]
                end else if (data_32) begin
                    next_reg_num = rm_f; // [RULE_07]
                    next_reg_size = mad_pkg::OPSZ_WORD; // [RULE_07]
                end else begin
                    next_reg_num = rm_f; // [RULE_06]
                    next_reg_size = mad_pkg::OPSZ_HALFWORD; // [RULE_06]
                end
            end else if (!addr_32) begin
                // 16-bit table [RULE_11]
                unique case (mod_f)
                    mad_pkg::MOD_DISP_BYTE: next_disp_size = mad_pkg::DISP_BYTE; // [RULE_03]
                    mad_pkg::MOD_DISP_WIDE: next_disp_size = mad_pkg::DISP_HALFWORD; // [RULE_03]
                    default: next_disp_size = mad_pkg::DISP_NONE; // [RULE_01]
                endcase
                // Index is source index for even codes, dest index for odd
                next_index_valid = (rm_f <= 3'h5); // [RULE_01]
                next_index = rm_f[0] ? mad_pkg::GR_DEST_IDX : mad_pkg::GR_SRC_IDX;
                next_base_valid = (rm_f <= 3'h3) || (rm_f >= 3'h6); // [RULE_01]
                next_base = (rm_f == 3'h2 || rm_f == 3'h3 || rm_f == 3'h6) ?
                    mad_pkg::GR_FRAME : mad_pkg::GR_BASE;
                if (mod_f == mad_pkg::MOD_NO_DISP && rm_f == mad_pkg::RM_DIRECT_16) begin
                    next_base_valid = 1'b0; // [RULE_02]
                    next_disp_size = mad_pkg::DISP_HALFWORD; // [RULE_02]
                end
                // Frame pointer forms default to the stack segment
                next_seg_stack = next_base_valid && (next_base == mad_pkg::GR_FRAME); // [RULE_04]
            end else begin
                // 32-bit table [RULE_11]
                unique case (mod_f)
                    mad_pkg::MOD_DISP_BYTE: next_disp_size = mad_pkg::DISP_BYTE; // [RULE_09]
                    mad_pkg::MOD_DISP_WIDE: next_disp_size = mad_pkg::DISP_WORD; // [RULE_09]
                    default: next_disp_size = mad_pkg::DISP_NONE; // [RULE_09]
                endcase
                if (rm_f == mad_pkg::RM_SIB) begin
                    // Base and index come from the following byte
                    next_sib_follows = 1'b1; // [RULE_08]
                end else if (mod_f == mad_pkg::MOD_NO_DISP && rm_f == mad_pkg::RM_DIRECT_32) begin
                    next_disp_size = mad_pkg::DISP_WORD; // [RULE_09]
                end else begin
                    next_base_valid = 1'b1; // [RULE_09]
                    next_base = rm_f; // [RULE_09]
                    next_seg_stack = (rm_f == mad_pkg::GR_FRAME); // [RULE_10]
                end
            end
        end
    end

    // Displacement value follows the decoded size
    always_comb begin
        next_disp = in_valid ? disp_ext : out_disp;
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_is_reg <= 1'b0;
            out_reg_num <= 3'h0;
            out_reg_high <= 1'b0;
            out_reg_size <= mad_pkg::OPSZ_BYTE;
            out_reg_field <= 3'h0;
            out_base_valid <= 1'b0;
            out_base <= 3'h0;
            out_index_valid <= 1'b0;
            out_index <= 3'h0;
            out_disp_size <= mad_pkg::DISP_NONE;
            out_disp <= '0;
            out_seg_stack <= 1'b0;
            out_sib_follows <= 1'b0;
        end else begin
            out_valid <= next_valid;
            out_is_reg <= next_is_reg;
            out_reg_num <= next_reg_num;
            out_reg_high <= next_reg_high;
            out_reg_size <= next_reg_size;
            out_reg_field <= next_reg_field;
            out_base_valid <= next_base_valid;
            out_base <= next_base;
            out_index_valid <= next_index_valid;
            out_index <= next_index;
            out_disp_size <= next_disp_size;
            out_disp <= next_disp;
            out_seg_stack <= next_seg_stack;
            out_sib_follows <= next_sib_follows;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Accepted byte in a given table, mode and code
    sequence s_take(logic a32, logic [1:0] m, logic [2:0] r);
        in_valid && (addr_32 == a32) && (mod_f == m) && (rm_f == r);
    endsequence

    // Accepted register-mode byte with given width and data size
    sequence s_take_reg(logic w, logic d32);
        in_valid && (mod_f == mad_pkg::MOD_REGISTER) && (width_bit == w) && (data_32 == d32);
    endsequence

    base_index_16_a: assert property (s_take(1'b0, 2'h0, 3'h0) |=> out_valid && // [RULE_01]
        out_base_valid && out_base == mad_pkg::GR_BASE && out_index_valid &&
        out_index == mad_pkg::GR_SRC_IDX && out_disp_size == mad_pkg::DISP_NONE)
        else $error("16-bit 00/000 not base plus source index");

    direct_16_a: assert property (s_take(1'b0, 2'h0, 3'h6) |=> !out_base_valid && // [RULE_02]
        !out_index_valid && out_disp_size == mad_pkg::DISP_HALFWORD && !out_seg_stack
        && out_disp == {16'h0, $past(disp_raw[15:0])})
        else $error("16-bit direct form wrong");

    disp_size_16_a: assert property (in_valid && !addr_32 && mod_f != mad_pkg::MOD_REGISTER // [RULE_03]
        |=> out_disp_size == ($past(mod_f) == 2'h1 ? mad_pkg::DISP_BYTE :
        $past(mod_f) == 2'h2 ? mad_pkg::DISP_HALFWORD :
        $past(rm_f) == 3'h6 ? mad_pkg::DISP_HALFWORD : mad_pkg::DISP_NONE))
        else $error("16-bit displacement size wrong");

    segment_16_a: assert property (in_valid && !addr_32 && mod_f != mad_pkg::MOD_REGISTER // [RULE_04]
        |=> out_seg_stack == ($past(rm_f) == 3'h2 || $past(rm_f) == 3'h3 ||
        ($past(rm_f) == 3'h6 && $past(mod_f) != 2'h0)))
        else $error("16-bit default segment wrong");

    // Index-only form: dest index plus byte, data segment
    index_only_16_a: assert property (s_take(1'b0, 2'h1, 3'h5) |=> // [RULE_01]
        !out_base_valid && out_index_valid && out_index == mad_pkg::GR_DEST_IDX &&
        !out_seg_stack && out_disp_size == mad_pkg::DISP_BYTE)
        else $error("16-bit index-only form wrong");

    // Frame pointer plus halfword, stack segment
    frame_16_a: assert property (s_take(1'b0, 2'h2, 3'h6) |=> out_base_valid && // [RULE_03]
        out_base == mad_pkg::GR_FRAME && !out_index_valid && out_seg_stack &&
        out_disp_size == mad_pkg::DISP_HALFWORD)
        else $error("16-bit frame pointer form wrong");

    byte_reg_a: assert property (s_take_reg(1'b0, data_32) |=> out_is_reg && // [RULE_05]
        out_reg_size == mad_pkg::OPSZ_BYTE && out_reg_high == $past(rm_f[2]) &&
        out_reg_num == {1'b0, $past(rm_f[1:0])})
        else $error("byte register select wrong");

    half_reg_a: assert property (s_take_reg(1'b1, 1'b0) |=> out_is_reg && // [RULE_06]
        out_reg_size == mad_pkg::OPSZ_HALFWORD && out_reg_num == $past(rm_f) && !out_reg_high)
        else $error("halfword register select wrong");

    word_reg_a: assert property (s_take_reg(1'b1, 1'b1) |=> out_is_reg && // [RULE_07]
        out_reg_size == mad_pkg::OPSZ_WORD && out_reg_num == $past(rm_f) && !out_base_valid)
        else $error("word register select wrong");

    sib_flag_a: assert property (in_valid |=> out_sib_follows == // [RULE_08]
        ($past(addr_32) && $past(rm_f) == 3'h4 && $past(mod_f) != mad_pkg::MOD_REGISTER))
        else $error("index byte flag wrong");

    direct_32_a: assert property (s_take(1'b1, 2'h0, 3'h5) |=> !out_base_valid && // [RULE_09]
        out_disp_size == mad_pkg::DISP_WORD && !out_seg_stack && out_disp == $past(disp_raw))
        else $error("32-bit direct form wrong");

    // Plain base register, no displacement, data segment
    base_32_a: assert property (s_take(1'b1, 2'h0, 3'h3) |=> out_base_valid && // [RULE_09]
        out_base == mad_pkg::GR_BASE && !out_seg_stack && !out_sib_follows &&
        out_disp_size == mad_pkg::DISP_NONE)
        else $error("32-bit base register form wrong");

    frame_32_a: assert property (s_take(1'b1, 2'h2, 3'h5) |=> out_base_valid && // [RULE_10]
        out_base == mad_pkg::GR_FRAME && out_seg_stack && out_disp_size == mad_pkg::DISP_WORD)
        else $error("32-bit frame base segment wrong");

    table_sel_a: assert property (in_valid && mod_f == 2'h0 && rm_f == 3'h6 // [RULE_11]
        |=> out_disp_size == ($past(addr_32) ? mad_pkg::DISP_NONE : mad_pkg::DISP_HALFWORD))
        else $error("address width table select wrong");

    byte_sext_a: assert property (in_valid && mod_f == 2'h1 // [RULE_12]
        |=> out_disp[7:0] == $past(disp_raw[7:0]) && out_disp[15:8] == {8{out_disp[7]}} &&
        out_disp[31:16] == ($past(addr_32) ? {16{out_disp[7]}} : 16'h0))
        else $error("byte displacement extension wrong");

    valid_follow_a: assert property (in_valid |=> out_valid)
        else $error("decode latency wrong");

    valid_drop_a: assert property (!in_valid |=> !out_valid)
        else $error("valid without accepted byte");

    // Fields keep their value while no byte is accepted
    field_hold_a: assert property (!in_valid |=> $stable(out_is_reg) && $stable(out_base)
        && $stable(out_disp_size) && $stable(out_disp) && $stable(out_seg_stack))
        else $error("decoded fields changed without a byte");

endmodule : mad_decoder

// file: sim/mad_feed.sv
// Prefetch queue model that presents addressing bytes to the decoder
`timescale 1ns/100ps

module mad_feed (
    output logic in_valid,
    output logic [7:0] modrm,
    output logic addr_32,
    output logic data_32,
    output logic width_bit,
    output logic [31:0] disp_raw
);

    // ------------------------------------------------------------
    // Byte presentation, called by the bench at the falling edge
    // ------------------------------------------------------------
    task automatic present(input logic [7:0] b, input logic a32, input logic d32,
                           input logic w, input logic [31:0] d);
        in_valid = 1'b1;
        modrm = b;
        addr_32 = a32; // Address width picks the table
        data_32 = d32;
        width_bit = w;
        disp_raw = d;
    endtask : present

    // Released lines show the inverse of their last value, so stale bytes never match
    task automatic idle();
        in_valid = 1'b0;
        modrm = ~modrm;
        addr_32 = ~addr_32;
        data_32 = ~data_32;
        width_bit = ~width_bit;
        disp_raw = ~disp_raw;
    endtask : idle

    // Quiet queue at time zero
    initial begin
        in_valid = 1'b0;
        modrm = 8'h00;
        addr_32 = 1'b0;
        data_32 = 1'b0;
        width_bit = 1'b0;
        disp_raw = 32'h0000_0000;
    end

endmodule : mad_feed

// file: sim/tb.sv
// Self-checking bench of the addressing byte decoder
`timescale 1ns/100ps

module tb;

    // ------------------------------------------------------------
    // Signals, counters and expected outputs
    // ------------------------------------------------------------
    logic clk_sys;
    logic sys_rst;
    logic in_valid, addr_32, data_32, width_bit;
    logic [7:0] modrm;
    logic [31:0] disp_raw;
    logic out_valid, out_is_reg, out_reg_high, out_base_valid, out_index_valid;
    logic out_seg_stack, out_sib_follows;
    logic [2:0] out_reg_num, out_reg_field, out_base, out_index;
    logic [31:0] out_disp;
    mad_pkg::mad_opsz_e out_reg_size;
    mad_pkg::mad_disp_e out_disp_size;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic e_reg, e_high, e_bv, e_iv, e_seg, e_sib;
    logic [2:0] e_num, e_field, e_base, e_idx;
    logic [31:0] e_disp;
    mad_pkg::mad_opsz_e e_size;
    mad_pkg::mad_disp_e e_dsz;

    mad_feed feed (.in_valid(in_valid), .modrm(modrm), .addr_32(addr_32),
        .data_32(data_32), .width_bit(width_bit), .disp_raw(disp_raw));

    mad_decoder #(.DISP_W(32)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .in_valid(in_valid),
        .modrm(modrm), .addr_32(addr_32), .data_32(data_32), .width_bit(width_bit),
        .disp_raw(disp_raw), .out_valid(out_valid), .out_is_reg(out_is_reg),
        .out_reg_num(out_reg_num), .out_reg_high(out_reg_high), .out_reg_size(out_reg_size),
        .out_reg_field(out_reg_field), .out_base_valid(out_base_valid), .out_base(out_base),
        .out_index_valid(out_index_valid), .out_index(out_index),
        .out_disp_size(out_disp_size), .out_disp(out_disp), .out_seg_stack(out_seg_stack),
        .out_sib_follows(out_sib_follows));

    // ------------------------------------------------------------
    // Clock, hang guard and closing report
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Cuts a hang short after far more cycles than the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 2000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Counts: %0d checked, %0d failed", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // ------------------------------------------------------------
    // Expected decode worked out from the address tables
    // ------------------------------------------------------------
    task automatic predict(input logic [7:0] b, input logic a32, input logic d32,
                           input logic w, input logic [31:0] d);
        logic [1:0] m;
        logic [2:0] rm;
        m = b[7:6];
        rm = b[2:0];
        e_field = b[5:3];
        e_reg = (m == 2'h3);
        {e_bv, e_base, e_iv, e_idx, e_seg, e_sib} = 10'h000;
        e_num = w ? rm : {1'b0, rm[1:0]};
        e_high = ~w & rm[2];
        e_size = !w ? mad_pkg::OPSZ_BYTE : d32 ? mad_pkg::OPSZ_WORD : mad_pkg::OPSZ_HALFWORD;
        e_dsz = (m == 2'h1) ? mad_pkg::DISP_BYTE : (m != 2'h2) ? mad_pkg::DISP_NONE :
            a32 ? mad_pkg::DISP_WORD : mad_pkg::DISP_HALFWORD;
        if (!a32) begin
            e_iv = (rm < 3'h6);
            e_idx = rm[0] ? 3'h7 : 3'h6;
            e_bv = (rm < 3'h4) || rm == 3'h7 || (rm == 3'h6 && m != 2'h0);
            e_base = (rm == 3'h0 || rm == 3'h1 || rm == 3'h7) ? 3'h3 : 3'h5;
            e_seg = (rm == 3'h2) || (rm == 3'h3) || (rm == 3'h6 && m != 2'h0);
            if (m == 2'h0 && rm == 3'h6) e_dsz = mad_pkg::DISP_HALFWORD;
        end else if (rm == 3'h4) begin
            e_sib = 1'b1;
        end else if (m == 2'h0 && rm == 3'h5) begin
            e_dsz = mad_pkg::DISP_WORD;
        end else begin
            e_bv = 1'b1;
            e_base = rm;
            e_seg = (rm == 3'h5);
        end
        case (e_dsz)
            mad_pkg::DISP_BYTE: e_disp = a32 ? {{24{d[7]}}, d[7:0]} : {16'h0000, {8{d[7]}}, d[7:0]};
            mad_pkg::DISP_HALFWORD: e_disp = {16'h0000, d[15:0]};
            mad_pkg::DISP_WORD: e_disp = d;
            default: e_disp = 32'h0000_0000;
        endcase
    endtask : predict

    // Compares valid, is_reg, reg_field and the register or address outputs of the decoded form with the expected decode
    task automatic check_out(input logic exp_v);
        chk(32'(out_valid), 32'(exp_v), "valid");
        chk(32'(out_is_reg), 32'(e_reg), "is_reg");
        chk(32'(out_reg_field), 32'(e_field), "reg_field");
        if (e_reg) begin
            chk(32'(out_reg_num), 32'(e_num), "reg_num");
            chk(32'(out_reg_high), 32'(e_high), "reg_high");
            chk(32'(out_reg_size), 32'(e_size), "reg_size");
            chk(32'({out_base_valid, out_index_valid}), 32'h0, "no address");
        end else begin
            chk(32'(out_base_valid), 32'(e_bv), "base_valid");
            if (e_bv) chk(32'(out_base), 32'(e_base), "base");
            chk(32'(out_index_valid), 32'(e_iv), "index_valid");
            if (e_iv) chk(32'(out_index), 32'(e_idx), "index");
            chk(32'(out_disp_size), 32'(e_dsz), "disp_size");
            chk(out_disp, e_disp, "disp");
            chk(32'(out_seg_stack), 32'(e_seg), "seg_stack");
            chk(32'(out_sib_follows), 32'(e_sib), "sib_follows");
        end
    endtask : check_out

    // Presents one byte at the falling edge and judges it one cycle later
    task automatic xfer(input logic [7:0] b, input logic a32, input logic d32,
                        input logic w, input logic [31:0] d);
        feed.present(b, a32, d32, w, d);
        predict(b, a32, d32, w, d);
        @(negedge clk_sys);
        check_out(1'b1);
    endtask : xfer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_memory(input logic a32);
        for (int i = 0; i < 24; i++) begin
            xfer({i[4:3], i[2:0] ^ 3'h5, i[2:0]}, a32, i[0], i[1],
                i[0] ? 32'h1234_5a9c : 32'h89ab_c37f);
        end
        feed.idle();
        @(negedge clk_sys);
        check_out(1'b0);
        $display("Test memory forms addr_32=%0d done", a32);
    endtask : t_memory

    task automatic t_register();
        for (int i = 0; i < 32; i++) begin
            xfer({2'h3, 3'(7 - i), i[2:0]}, i[0], i[4], i[3], 32'h0f0f_8080);
        end
        feed.idle();
        @(negedge clk_sys);
        check_out(1'b0);
        $display("Test register forms done");
    endtask : t_register

    task automatic t_slow_reset();
        xfer(8'h46, 1'b0, 1'b0, 1'b1, 32'h5555_55ff);
        feed.idle();
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_sys);
            check_out(1'b0);
        end
        sys_rst = 1'b1;
        @(negedge clk_sys);
        chk(32'({out_valid, out_is_reg, out_seg_stack, out_base_valid}), 32'h0, "reset outs");
        chk(out_disp, 32'h0000_0000, "reset disp");
        sys_rst = 1'b0;
        xfer(8'h85, 1'b1, 1'b1, 1'b0, 32'hfedc_ba98);
        xfer(8'h06, 1'b0, 1'b1, 1'b0, 32'h0000_8001);
        feed.idle();
        @(negedge clk_sys);
        $display("Test slow queue and reset done");
    endtask : t_slow_reset

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_memory(1'b0);
        t_memory(1'b1);
        t_register();
        t_slow_reset();
        close_out();
    end

endmodule : tb
